// File: tb/dlg_loop_gain_cfg_chk.sv
`timescale 1ns/1ns
module dlg_loop_gain_cfg_chk
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [2:0] main_bw_class,
  input wire logic sec_digital_mode,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit,
  input wire logic [2:0] main_loop_damping_code,
  input wire logic [7:0] main_damping_factor,
  input wire logic [2:0] main_pd_gain,
  input wire logic sec_gain_override
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence main_wr;
    wr_en && addr == 8'h6B;
  endsequence
  a_reset_values: assert property ($rose(rstn) |-> main_loop_damping_code == 3'h3)
    else $error("damping code wrong after reset");
  a_code_written: assert property (main_wr |-> ##2 main_loop_damping_code == $past(wr_data[2:0], 2))
    else $error("damping code not taken from write");
  a_low_gain_written: assert property (main_wr |-> ##2 main_pd_gain == $past(wr_data[6:4], 2))
    else $error("low rate gain not taken from write");
  a_slow_bw_clamp: assert property (main_bw_class == 3'h0 |=> main_damping_factor == 8'h32)
    else $error("slow bandwidth factor not clamped");
  a_digital_gain: assert property (sec_digital_mode [*2] |-> sec_gain_override)
    else $error("digital gain not applied");
  a_mapped_read: assert property (rd_en && (addr == 8'h6B || addr == 8'h6C) |=> rd_hit)
    else $error("mapped read gave no hit");
  a_unmapped_read: assert property (rd_en && addr != 8'h6B && addr != 8'h6C
    |=> !rd_hit && rd_data == 8'h00)
    else $error("unmapped read answered");
endmodule : dlg_loop_gain_cfg_chk
bind dlg_loop_gain_cfg dlg_loop_gain_cfg_chk u_chk (.*);

// File: tb/test_dlg_loop_gain_cfg.sv
`timescale 1ns/1ns
module test_dlg_loop_gain_cfg;
  logic ref_clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, main_low_rate_ref = 1'b1;
  logic sec_digital_mode = 1'b0, sec_high_rate_ref = 1'b0, rd_hit, main_gain_override;
  logic sec_gain_override;
  logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, main_damping_factor;
  logic [2:0] main_bw_class = 3'h4, main_loop_damping_code, main_pd_gain, sec_pd_gain;
  logic [7:0] f70 [5] = '{8'h0C, 8'h19, 8'h32, 8'h64, 8'hC8};
  logic [15:0] sec_tab [4] = '{16'hA63A, 16'hA65E, 16'h2620, 16'h267E};
  int failures = 0, comparisons = 0, cyc = 0;
  dlg_loop_gain_cfg DUT (.*);
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (++cyc == 1000)
    begin
      failures++;
      summarize();
    end
  task summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one strobe cycle; read data is settled 1 ns after the taking edge
  task acc(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1;
  endtask : acc
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    acc(0, 8'h6B, 0);
    chk("main reg", 8'h13, rd_data);
    acc(0, 8'h6C, 0);
    chk("sec reg", 8'hC2, rd_data);
    acc(0, 8'h6D, 0);
    chk("unmapped", 8'h00, {rd_data[7:1], rd_hit});
    acc(1, 8'h6B, 8'hFF);
    acc(0, 8'h6B, 0);
    chk("main rw", 8'h77, rd_data);
    chk("main gain", 8'h07, {5'h00, main_pd_gain});
    chk("main code", 8'h07, {5'h00, main_loop_damping_code});
    chk("unused code factor", 8'h32, main_damping_factor);
    main_bw_class <= 3'h3;
    acc(1, 8'h6B, 8'h05);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("factor 35", 8'h64, main_damping_factor);
    main_bw_class <= 3'h1;
    acc(1, 8'h6B, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("factor 8", 8'h19, main_damping_factor);
    for (int b = 0; b < 2; b++)
      foreach (f70[i])
      begin
        main_bw_class <= b ? 3'h0 : 3'h4;
        acc(1, 8'h6B, 8'(i + 1));
        repeat (2) @(posedge ref_clk);
        #1;
        chk("factor", b ? 8'h32 : f70[i], main_damping_factor);
      end
    foreach (sec_tab[i])
    begin
      acc(1, 8'h6C, sec_tab[i][15:8]);
      @(posedge ref_clk);
      sec_digital_mode <= sec_tab[i][6];
      sec_high_rate_ref <= sec_tab[i][5];
      repeat (2) @(posedge ref_clk);
      #1;
      chk("sec gain", {4'h0, sec_tab[i][4], sec_tab[i][2:0]},
        {4'h0, sec_gain_override, sec_pd_gain & {3{sec_tab[i][3]}}});
    end
    acc(1, 8'h6C, 8'hA6);
    sec_digital_mode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("main ovr on", 8'h01, {7'h00, main_gain_override});
    main_low_rate_ref <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("main ovr off", 8'h00, {7'h00, main_gain_override});
    summarize();
  end
endmodule : test_dlg_loop_gain_cfg

// File: verilog/dlg_damping_lut.sv
`timescale 1ns/1ns
module dlg_damping_lut
(
  input wire logic [2:0] code,
  input wire logic [2:0] bw_class,
  output logic [7:0] factor
);
  logic [7:0] full;
  always_comb
  begin
    case (code)
      3'h1: full = dlg_pkg::DLG_DF_1P2;
      3'h2: full = dlg_pkg::DLG_DF_2P5;
      3'h3: full = dlg_pkg::DLG_DF_5;
      3'h4: full = dlg_pkg::DLG_DF_10;
      3'h5: full = dlg_pkg::DLG_DF_20;
      // unused codes fall back to the default factor
      default: full = dlg_pkg::DLG_DF_5;
    endcase
    factor = full;
    case (bw_class)
      dlg_pkg::DLG_BW_4HZ: factor = dlg_pkg::DLG_DF_5;
      dlg_pkg::DLG_BW_8HZ:
        if (full < dlg_pkg::DLG_DF_2P5) factor = dlg_pkg::DLG_DF_2P5;
        else factor = dlg_pkg::DLG_DF_5;
      dlg_pkg::DLG_BW_18HZ:
        if (full > dlg_pkg::DLG_DF_5) factor = dlg_pkg::DLG_DF_5;
        else factor = full;
      dlg_pkg::DLG_BW_35HZ:
        if (full > dlg_pkg::DLG_DF_10) factor = dlg_pkg::DLG_DF_10;
        else factor = full;
      default: factor = full;
    endcase
  end
endmodule : dlg_damping_lut

// File: verilog/dlg_loop_gain_cfg.sv
`timescale 1ns/1ns
module dlg_loop_gain_cfg
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [2:0] main_bw_class,
  input wire logic main_low_rate_ref,
  input wire logic sec_digital_mode,
  input wire logic sec_high_rate_ref,
  output logic [7:0] rd_data,
  output logic rd_hit,
  output logic [2:0] main_loop_damping_code,
  output logic [7:0] main_damping_factor,
  output logic main_gain_override,
  output logic [2:0] main_pd_gain,
  output logic sec_gain_override,
  output logic [2:0] sec_pd_gain
);
  logic [7:0] main_reg;
  logic [7:0] sec_reg;
  logic [7:0] next_main_reg;
  logic [7:0] next_sec_reg;
  logic [7:0] next_rd_data;
  logic next_rd_hit;
  logic [7:0] factor_c;
  logic next_main_ovr;
  logic [2:0] next_main_gain;
  logic next_sec_ovr;
  logic [2:0] next_sec_gain;

  dlg_damping_lut u_lut
  (
    .code(main_reg[2:0]),
    .bw_class(main_bw_class),
    .factor(factor_c)
  );

  always_comb
  begin
    next_main_reg = main_reg;
    next_sec_reg = sec_reg;
    next_rd_data = 8'h00;
    next_rd_hit = 1'b0;
    // codes 000/111 are stored as written; the lookup falls back to default
    if (wr_en && addr == dlg_pkg::DLG_MAIN_DAMP_OFFSET)
      next_main_reg = wr_data & dlg_pkg::DLG_MAIN_DAMP_MASK;
    if (wr_en && addr == dlg_pkg::DLG_SEC_GAIN_OFFSET)
      next_sec_reg = wr_data & dlg_pkg::DLG_SEC_GAIN_MASK;
    if (rd_en)
    begin
      case (addr)
        dlg_pkg::DLG_MAIN_DAMP_OFFSET:
        begin
          next_rd_data = main_reg;
          next_rd_hit = 1'b1;
        end
        dlg_pkg::DLG_SEC_GAIN_OFFSET:
        begin
          next_rd_data = sec_reg;
          next_rd_hit = 1'b1;
        end
        default: next_rd_data = 8'h00;
      endcase
    end
    // main analog gain only below or at 8 kHz, gated by the secondary enable
    next_main_ovr = sec_reg[dlg_pkg::DLG_ENABLE_BIT] && !sec_digital_mode
      && main_low_rate_ref;
    next_main_gain = main_reg[dlg_pkg::DLG_AGAIN_LSB +: 3];
    if (sec_digital_mode)
    begin
      next_sec_ovr = 1'b1;
      next_sec_gain = sec_reg[dlg_pkg::DLG_CODE_LSB +: 3];
    end
    else
    begin
      next_sec_ovr = sec_reg[dlg_pkg::DLG_ENABLE_BIT] && sec_high_rate_ref;
      next_sec_gain = sec_reg[dlg_pkg::DLG_AGAIN_LSB +: 3];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      main_reg <= dlg_pkg::DLG_MAIN_DAMP_RESET;
      sec_reg <= dlg_pkg::DLG_SEC_GAIN_RESET;
      rd_data <= 8'h00;
      rd_hit <= 1'b0;
      main_loop_damping_code <= dlg_pkg::DLG_MAIN_DAMP_RESET[2:0];
      main_damping_factor <= dlg_pkg::DLG_DF_5;
      main_gain_override <= 1'b0;
      main_pd_gain <= 3'h0;
      sec_gain_override <= 1'b0;
      sec_pd_gain <= 3'h0;
    end
    else
    begin
      main_reg <= next_main_reg;
      sec_reg <= next_sec_reg;
      rd_data <= next_rd_data;
      rd_hit <= next_rd_hit;
      main_loop_damping_code <= main_reg[2:0];
      main_damping_factor <= factor_c;
      main_gain_override <= next_main_ovr;
      main_pd_gain <= next_main_gain;
      sec_gain_override <= next_sec_ovr;
      sec_pd_gain <= next_sec_gain;
    end
  end
endmodule : dlg_loop_gain_cfg

// File: verilog/dlg_pkg.sv
package dlg_pkg;
  localparam logic [7:0] DLG_MAIN_DAMP_OFFSET = 8'h6B;
  localparam logic [7:0] DLG_SEC_GAIN_OFFSET = 8'h6C;
  localparam logic [7:0] DLG_MAIN_DAMP_RESET = 8'h13;
  localparam logic [7:0] DLG_SEC_GAIN_RESET = 8'hC2;
  localparam logic [7:0] DLG_MAIN_DAMP_MASK = 8'h77;
  localparam logic [7:0] DLG_SEC_GAIN_MASK = 8'hF7;
  localparam int DLG_CODE_LSB = 0;
  localparam int DLG_AGAIN_LSB = 4;
  localparam int DLG_ENABLE_BIT = 7;
  // bandwidth classes
  localparam logic [2:0] DLG_BW_4HZ = 3'h0;
  localparam logic [2:0] DLG_BW_8HZ = 3'h1;
  localparam logic [2:0] DLG_BW_18HZ = 3'h2;
  localparam logic [2:0] DLG_BW_35HZ = 3'h3;
  localparam logic [2:0] DLG_BW_70HZ = 3'h4;
  // damping factor encoding, tenths of a unit
  localparam logic [7:0] DLG_DF_1P2 = 8'h0C;
  localparam logic [7:0] DLG_DF_2P5 = 8'h19;
  localparam logic [7:0] DLG_DF_5 = 8'h32;
  localparam logic [7:0] DLG_DF_10 = 8'h64;
  localparam logic [7:0] DLG_DF_20 = 8'hC8;
endpackage : dlg_pkg
